// >>> rorm_loss_timer.sv
// Purpose: measures silence on the bus in tenths of a second
// Assumes: activity is a one-cycle pulse per frame addressed to this node
// Notes: fires once per silence, re-armed by the next activity
`timescale 1ns/1ps
module rorm_loss_timer #(
    parameter int unsigned TICK_CYCLES = rorm_pkg::TENTH_CYCLES
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic activity,
    input wire logic [7:0] limit,
    output logic expired,
    output logic expire_pulse
);

    logic [31:0] div_reg;
    logic [7:0] tenths_reg;
    logic tick;

    assign tick = (div_reg == 32'(TICK_CYCLES - 1));

    // tenth-second divider, restarted by activity
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= '0;
        end else if (activity || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 32'h0000_0001;
        end
    end

    // silence counter in tenths
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tenths_reg <= '0;
        end else if (activity) begin
            tenths_reg <= '0;
        end else if (tick && !expired) begin
            tenths_reg <= tenths_reg + 8'h01;
        end
    end

    // expiry level and single pulse
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            expired <= 1'b0;
            expire_pulse <= 1'b0;
        end else if (activity) begin
            expired <= 1'b0;
            expire_pulse <= 1'b0;
        end else begin
            expire_pulse <= !expired && (tenths_reg >= limit);
            expired <= expired || (tenths_reg >= limit);
        end
    end

endmodule : rorm_loss_timer

// >>> rorm_master_model.sv
// Purpose: frame handler side that issues register and coil requests
// Assumes: one request at a time, answer registered on the same edge that takes it
// Notes: released request lines carry the inverse of the last value
`timescale 1ns/1ps
module rorm_master_model (
    input wire logic ref_clk,
    output rorm_pkg::rorm_req_t req,
    input wire rorm_pkg::rorm_rsp_t rsp
);
    ////////////////////////////////////////////////////////////////
    // idle request at time zero
    initial begin
        req = '0;
    end

    ////////////////////////////////////////////////////////////////
    // one request held for one taking edge, answer read where it stands
    task automatic xfer(input logic wr, input logic cl, input logic [15:0] a, input logic [15:0] d,
                        output rorm_pkg::rorm_rsp_t r);
        @(posedge ref_clk);
        req <= '{valid: 1'b1, write: wr, coil: cl, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '{valid: 1'b0, write: ~wr, coil: ~cl, addr: ~a, wdata: ~d};
        #1;
        r = rsp;
    endtask : xfer

    ////////////////////////////////////////////////////////////////
    // new line word, then module reset so that it takes effect
    task automatic apply_line(input logic [15:0] d, output rorm_pkg::rorm_rsp_t r);
        xfer(1'b1, 1'b0, rorm_pkg::OFF_LINE, d, r);
        xfer(1'b1, 1'b0, rorm_pkg::OFF_RESET, 16'h0001, r);
    endtask : apply_line
endmodule : rorm_master_model

// >>> rorm_pkg.sv
// Purpose: shared constants and carriers of the relay output register map
// Assumes: 16-bit holding words and single-bit coils, one request at a time
// Notes: offsets are the protocol addresses seen by the frame handler
package rorm_pkg;

    // holding register addresses
    localparam logic [15:0] OFF_OUTPUT = 16'h9C42;
    localparam logic [15:0] OFF_FAULT = 16'h9C43;
    localparam logic [15:0] OFF_TIMEOUT = 16'h9C44;
    localparam logic [15:0] OFF_FLAGS = 16'h9C45;
    localparam logic [15:0] OFF_LINE = 16'h9C46;
    localparam logic [15:0] OFF_RESET = 16'h9C47;
    localparam logic [15:0] OFF_SWITCH = 16'h9C48;
    // non-volatile copy addresses
    localparam logic [15:0] NV_FAULT = 16'h9C83;
    localparam logic [15:0] NV_TIMEOUT = 16'h9C84;
    localparam logic [15:0] NV_FLAGS = 16'h9C85;
    localparam logic [15:0] NV_LINE = 16'h9C86;
    // coil addresses
    localparam logic [15:0] COIL_FIRST = 16'h0001;
    localparam logic [15:0] COIL_LAST = 16'h0005;

    // field positions
    localparam int CHANNELS = 5;
    localparam int FAULT_EN_BIT = 7;
    localparam int RESET_BIT = 0;

    // reset values and ranges
    localparam logic [4:0] OUTPUT_RST = 5'h00;
    localparam logic [4:0] FAULT_RST = 5'h00;
    localparam logic [15:0] TIMEOUT_RST = 16'h0064;
    localparam logic [15:0] TIMEOUT_MIN = 16'h0005;
    localparam logic [15:0] TIMEOUT_MAX = 16'h00FA;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h03;
    localparam logic [7:0] BAUD_MAX = 8'h07;
    localparam logic [7:0] NODE_RST = 8'h01;
    localparam logic [7:0] NODE_MIN = 8'h01;

    // timing: the timeout counts in units of a tenth of a second
    localparam int LOSS_UNIT_MS = 100;
    localparam int CLK_MHZ = 200;
    localparam int TENTH_CYCLES = LOSS_UNIT_MS * 1000 * CLK_MHZ;

    // request from the frame handler
    typedef struct packed {
        logic valid;
        logic write;
        logic coil;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rorm_req_t;

    // answer to the frame handler
    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } rorm_rsp_t;

endpackage : rorm_pkg

// >>> rorm_register_map.sv
// Purpose: register map of a five-channel relay output node
// Assumes: a frame handler on the same clock hands decoded requests in
// Notes: answer comes one cycle after each request
`timescale 1ns/1ps
module rorm_register_map #(
    parameter int unsigned TICK_CYCLES = rorm_pkg::TENTH_CYCLES
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire rorm_pkg::rorm_req_t req,
    output rorm_pkg::rorm_rsp_t rsp,
    input wire logic bus_activity,
    input wire logic [7:0] switch_pins,
    output logic [4:0] relay_drive,
    output logic [4:0] led_drive,
    output logic [7:0] baud_code,
    output logic [7:0] node_addr,
    output logic nv_write,
    output logic [15:0] nv_addr,
    output logic [15:0] nv_data
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // holding word hit
    function automatic logic word_hit(input rorm_pkg::rorm_req_t r, input logic [15:0] off);
        word_hit = r.valid && !r.coil && (r.addr == off);
    endfunction : word_hit

    // coil address in range
    function automatic logic coil_hit(input rorm_pkg::rorm_req_t r);
        coil_hit = r.valid && r.coil && (r.addr >= rorm_pkg::COIL_FIRST) && (r.addr <= rorm_pkg::COIL_LAST);
    endfunction : coil_hit

    logic [7:0] sw_sync;
    logic [4:0] out_reg;
    logic [4:0] fault_reg;
    logic [15:0] timeout_reg;
    logic [7:0] flag_reg;
    logic [15:0] line_reg;
    logic [7:0] baud_reg;
    logic [7:0] node_reg;
    logic apply_reg;
    rorm_pkg::rorm_rsp_t rsp_reg;
    rorm_pkg::rorm_rsp_t rsp_next;
    logic legal;
    logic wr_ok;
    logic [2:0] cidx;
    logic loss_expired;
    logic loss_pulse;
    logic fault_take;

    rorm_sync #(
        .W(8)
    ) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pins(switch_pins),
        .pins_sync(sw_sync)
    );

    rorm_loss_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .activity(bus_activity),
        .limit(timeout_reg[7:0]),
        .expired(loss_expired),
        .expire_pulse(loss_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode and range checks

    assign cidx = 3'(req.addr[2:0] - 3'h1);
    assign wr_ok = req.valid && req.write && legal;
    assign fault_take = loss_pulse && flag_reg[rorm_pkg::FAULT_EN_BIT];

    // legality of the presented request
    always_comb begin
        legal = 1'b0;
        if (req.coil) begin
            legal = coil_hit(req);
        end else begin
            case (req.addr)
                rorm_pkg::OFF_OUTPUT, rorm_pkg::OFF_FAULT, rorm_pkg::OFF_FLAGS, rorm_pkg::OFF_RESET: begin
                    legal = 1'b1;
                end
                rorm_pkg::OFF_TIMEOUT: begin
                    legal = !req.write || ((req.wdata >= rorm_pkg::TIMEOUT_MIN)
                        && (req.wdata <= rorm_pkg::TIMEOUT_MAX));
                end
                rorm_pkg::OFF_LINE: begin
                    legal = !req.write || ((req.wdata[15:8] <= rorm_pkg::BAUD_MAX)
                        && (req.wdata[7:0] >= rorm_pkg::NODE_MIN));
                end
                rorm_pkg::OFF_SWITCH: begin
                    legal = !req.write;
                end
                default: begin
                    legal = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage

    // output word, shared by coils and word path
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_reg <= rorm_pkg::OUTPUT_RST;
        end else if (wr_ok && word_hit(req, rorm_pkg::OFF_OUTPUT)) begin
            out_reg <= req.wdata[4:0];
        end else if (wr_ok && coil_hit(req)) begin
            out_reg[cidx] <= req.wdata[0];
        end else if (fault_take) begin
            out_reg <= fault_reg;
        end
    end

    // fault values
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fault_reg <= rorm_pkg::FAULT_RST;
        end else if (wr_ok && word_hit(req, rorm_pkg::OFF_FAULT)) begin
            fault_reg <= req.wdata[4:0];
        end
    end

    // timeout and flag words
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timeout_reg <= rorm_pkg::TIMEOUT_RST;
            flag_reg <= rorm_pkg::FLAGS_RST;
        end else if (wr_ok && word_hit(req, rorm_pkg::OFF_TIMEOUT)) begin
            timeout_reg <= req.wdata;
        end else if (wr_ok && word_hit(req, rorm_pkg::OFF_FLAGS)) begin
            flag_reg <= req.wdata[7:0];
        end
    end

    // stored line word, not yet in force
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            line_reg <= {rorm_pkg::BAUD_RST, rorm_pkg::NODE_RST};
        end else if (wr_ok && word_hit(req, rorm_pkg::OFF_LINE)) begin
            line_reg <= req.wdata;
        end
    end

    // module reset request, self clearing
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            apply_reg <= 1'b0;
        end else begin
            apply_reg <= wr_ok && word_hit(req, rorm_pkg::OFF_RESET) && req.wdata[rorm_pkg::RESET_BIT];
        end
    end

    // line settings in force
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            baud_reg <= rorm_pkg::BAUD_RST;
            node_reg <= rorm_pkg::NODE_RST;
        end else if (apply_reg) begin
            baud_reg <= line_reg[15:8];
            node_reg <= line_reg[7:0];
        end
    end

    // non-volatile copy requests
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            nv_write <= 1'b0;
            nv_addr <= '0;
            nv_data <= '0;
        end else begin
            nv_write <= wr_ok && !req.coil && ((req.addr == rorm_pkg::OFF_FAULT)
                || (req.addr == rorm_pkg::OFF_TIMEOUT) || (req.addr == rorm_pkg::OFF_FLAGS)
                || (req.addr == rorm_pkg::OFF_LINE));
            nv_addr <= req.addr + (rorm_pkg::NV_FAULT - rorm_pkg::OFF_FAULT);
            nv_data <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path and answer

    // read data selection
    always_comb begin
        rsp_next = '0;
        rsp_next.ack = req.valid;
        rsp_next.err = req.valid && !legal;
        if (coil_hit(req)) begin
            rsp_next.rdata = {15'h0000, out_reg[cidx]};
        end else if (!req.coil) begin
            case (req.addr)
                rorm_pkg::OFF_OUTPUT: rsp_next.rdata = {11'h000, out_reg};
                rorm_pkg::OFF_FAULT: rsp_next.rdata = {11'h000, fault_reg};
                rorm_pkg::OFF_TIMEOUT: rsp_next.rdata = timeout_reg;
                rorm_pkg::OFF_FLAGS: rsp_next.rdata = {8'h00, flag_reg};
                rorm_pkg::OFF_LINE: rsp_next.rdata = line_reg;
                rorm_pkg::OFF_SWITCH: rsp_next.rdata = {8'h00, sw_sync};
                default: rsp_next.rdata = 16'h0000;
            endcase
        end
        if (!legal) begin
            rsp_next.rdata = 16'h0000;
        end
    end

    // registered answer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign rsp = rsp_reg;
    assign relay_drive = out_reg;
    assign led_drive = out_reg;
    assign baud_code = baud_reg;
    assign node_addr = node_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence line_write_s;
        req.valid && req.write && !req.coil && (req.addr == rorm_pkg::OFF_LINE) && legal;
    endsequence

    sequence reset_write_s;
        req.valid && req.write && !req.coil && (req.addr == rorm_pkg::OFF_RESET) && req.wdata[0];
    endsequence

    // register port answers and storage
    sw_high_a: assert property (req.valid && !req.write && !req.coil && (req.addr == rorm_pkg::OFF_SWITCH)
        |=> rsp.ack && (rsp.rdata[7:6] == $past(sw_sync[7:6]))) else $error("switch bits 7:6 wrong");
    sw_low_a: assert property (req.valid && !req.coil && (req.addr == rorm_pkg::OFF_SWITCH)
        |=> (rsp.err == $past(req.write)) && ($past(req.write) || (rsp.rdata[5:0] == $past(sw_sync[5:0]))))
        else $error("switch bits 5:0 wrong");
    baud_apply_a: assert property (line_write_s
        ##1 !(req.valid && !req.coil && (req.addr == rorm_pkg::OFF_LINE)) ##1 reset_write_s
        |-> ##2 (baud_code == $past(req.wdata[15:8], 4))) else $error("baud code not applied");
    node_range_a: assert property (req.valid && req.write && !req.coil && (req.addr == rorm_pkg::OFF_LINE)
        && (req.wdata[7:0] == 8'h00) |=> $stable(line_reg) && rsp.err) else $error("node zero accepted");
    out_word_a: assert property (req.valid && req.write && !req.coil && (req.addr == rorm_pkg::OFF_OUTPUT)
        |=> (relay_drive == $past(req.wdata[4:0])) && (led_drive == relay_drive))
        else $error("output word not driven");
    fault_word_a: assert property (req.valid && req.write && !req.coil && (req.addr == rorm_pkg::OFF_FAULT)
        |=> fault_reg == $past(req.wdata[4:0])) else $error("fault word not stored");
    tmo_range_a: assert property (req.valid && req.write && !req.coil && (req.addr == rorm_pkg::OFF_TIMEOUT)
        && ((req.wdata < 16'h0005) || (req.wdata > 16'h00FA)) |=> $stable(timeout_reg))
        else $error("timeout out of range");
    tmo_store_a: assert property (req.valid && req.write && !req.coil && (req.addr == rorm_pkg::OFF_TIMEOUT)
        && legal |=> (timeout_reg == $past(req.wdata)) && (nv_addr == rorm_pkg::NV_TIMEOUT))
        else $error("timeout not stored");
    fault_copy_a: assert property (fault_take && !(req.valid && req.write)
        |=> relay_drive == $past(fault_reg)) else $error("fault values not imposed");
    coil_write_a: assert property (req.valid && req.write && req.coil && (req.addr == 16'h0001)
        |=> relay_drive[0] == $past(req.wdata[0])) else $error("coil one not driven");
    coil_range_a: assert property (req.valid && req.coil && !fault_take
        && ((req.addr < rorm_pkg::COIL_FIRST) || (req.addr > rorm_pkg::COIL_LAST))
        |=> rsp.err && $stable(relay_drive)) else $error("stray coil accepted");
    line_hold_a: assert property (line_write_s ##0 !apply_reg
        |=> $stable(baud_code) [*2]) else $error("line applied early");
    coil_mirror_a: assert property (req.valid && !req.write && req.coil && (req.addr == 16'h0005)
        |=> rsp.rdata[0] == $past(out_reg[4])) else $error("coil read mismatch");

    // loss timer and non-volatile copies
    fault_once_a: assert property (loss_expired && !bus_activity
        |=> !loss_pulse) else $error("fault copy repeated");
    no_enable_a: assert property (loss_pulse && !flag_reg[rorm_pkg::FAULT_EN_BIT] && !req.valid
        |=> $stable(relay_drive)) else $error("fault copy while disabled");
    nv_fault_a: assert property (req.valid && req.write && !req.coil && (req.addr == rorm_pkg::OFF_FAULT)
        |=> nv_write && (nv_addr == rorm_pkg::NV_FAULT) && (nv_data == $past(req.wdata)))
        else $error("fault word not kept");
    nv_line_a: assert property (line_write_s
        |=> nv_write && (nv_addr == rorm_pkg::NV_LINE) && (nv_data == $past(req.wdata)))
        else $error("line word not kept");

endmodule : rorm_register_map

// >>> rorm_register_map_bench.sv
// Purpose: self-checking bench of the relay output register map
// Assumes: loss timer tick shortened to 4 cycles
// Notes: all requests go through the master model tasks
`timescale 1ns/1ps
module rorm_register_map_bench;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic bus_activity = 1'b0;
    logic [7:0] switch_pins = 8'hA5;
    rorm_pkg::rorm_req_t req;
    rorm_pkg::rorm_rsp_t rsp;
    rorm_pkg::rorm_rsp_t r;
    logic [4:0] relay_drive;
    logic [4:0] led_drive;
    logic [7:0] baud_code;
    logic [7:0] node_addr;
    logic nv_write;
    logic [15:0] nv_addr;
    logic [15:0] nv_data;
    logic [15:0] tv [4] = '{16'h0004, 16'h00FB, 16'h00FA, 16'h0005};
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            stop_test();
        end
    end

    rorm_register_map #(.TICK_CYCLES(4)) rorm_register_map_i (.ref_clk(ref_clk), .nrst(nrst), .req(req),
        .rsp(rsp), .bus_activity(bus_activity), .switch_pins(switch_pins), .relay_drive(relay_drive),
        .led_drive(led_drive), .baud_code(baud_code), .node_addr(node_addr), .nv_write(nv_write),
        .nv_addr(nv_addr), .nv_data(nv_data));
    rorm_master_model rorm_master_model_i (.ref_clk(ref_clk), .req(req), .rsp(rsp));

    ////////////////////////////////////////////////////////////////
    // compare, access helpers and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic cl, input logic [15:0] a, input logic [15:0] d, input logic e);
        rorm_master_model_i.xfer(1'b1, cl, a, d, r);
        check({14'h0, r.ack, r.err}, {14'h0, 1'b1, e});
    endtask : wr

    task automatic rd(input logic cl, input logic [15:0] a, input logic [15:0] exp);
        rorm_master_model_i.xfer(1'b0, cl, a, 16'h0000, r);
        check({14'h0, r.ack, r.err}, 16'h0002);
        check(r.rdata, exp);
    endtask : rd

    task automatic pulse_activity;
        @(posedge ref_clk);
        bus_activity <= 1'b1;
        @(posedge ref_clk);
        bus_activity <= 1'b0;
    endtask : pulse_activity

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(1'b0, rorm_pkg::OFF_OUTPUT, 16'h0000);
        rd(1'b0, rorm_pkg::OFF_FAULT, 16'h0000);
        rd(1'b0, rorm_pkg::OFF_TIMEOUT, 16'h0064);
        rd(1'b0, rorm_pkg::OFF_LINE, 16'h0301);
        rd(1'b1, 16'h0001, 16'h0000);
        check({baud_code, node_addr}, 16'h0301);
        $display("reset values done");
        rd(1'b0, rorm_pkg::OFF_SWITCH, 16'h00A5);
        @(posedge ref_clk);
        switch_pins <= 8'h5A;
        repeat (3) @(posedge ref_clk);
        wr(1'b0, rorm_pkg::OFF_SWITCH, 16'h00FF, 1'b1);
        rd(1'b0, rorm_pkg::OFF_SWITCH, 16'h005A);
        $display("switch word done");
        wr(1'b0, rorm_pkg::OFF_OUTPUT, 16'h0015, 1'b0);
        check({3'h0, relay_drive, 3'h0, led_drive}, 16'h1515);
        for (int i = 0; i < 5; i++) begin
            rd(1'b1, 16'(i + 1), 16'((5'h15 >> i) & 5'h01));
        end
        wr(1'b1, 16'h0002, 16'h0001, 1'b0);
        rd(1'b0, rorm_pkg::OFF_OUTPUT, 16'h0017);
        wr(1'b1, 16'h0001, 16'h0000, 1'b0);
        check({3'h0, relay_drive, 3'h0, led_drive}, 16'h1616);
        wr(1'b1, 16'h0006, 16'h0001, 1'b1);
        wr(1'b1, 16'h0000, 16'h0001, 1'b1);
        $display("outputs and coils done");
        wr(1'b0, rorm_pkg::OFF_FAULT, 16'h000A, 1'b0);
        check({15'h0, nv_write}, 16'h0001);
        check(nv_addr, rorm_pkg::NV_FAULT);
        for (int i = 0; i < 4; i++) begin
            wr(1'b0, rorm_pkg::OFF_TIMEOUT, tv[i], i < 2);
        end
        check(nv_data, 16'h0005);
        check(nv_addr, rorm_pkg::NV_TIMEOUT);
        rd(1'b0, rorm_pkg::OFF_TIMEOUT, 16'h0005);
        $display("fault and timeout words done");
        wr(1'b0, rorm_pkg::OFF_LINE, 16'h0505, 1'b0);
        check(16'(baud_code), 16'h0003);
        wr(1'b0, rorm_pkg::OFF_RESET, 16'h0001, 1'b0);
        @(posedge ref_clk);
        #1;
        check({baud_code, node_addr}, 16'h0505);
        wr(1'b0, rorm_pkg::OFF_LINE, 16'h0801, 1'b1);
        wr(1'b0, rorm_pkg::OFF_LINE, 16'h0700, 1'b1);
        rd(1'b0, rorm_pkg::OFF_LINE, 16'h0505);
        for (int c = 0; c < 8; c++) begin
            rorm_master_model_i.apply_line({8'(c), 8'hFF}, r);
            @(posedge ref_clk);
            #1;
            check({baud_code, node_addr}, {8'(c), 8'hFF});
        end
        $display("line settings done");
        wr(1'b0, rorm_pkg::OFF_FLAGS, 16'h0080, 1'b0);
        rd(1'b0, rorm_pkg::OFF_FLAGS, 16'h0080);
        wr(1'b0, rorm_pkg::OFF_OUTPUT, 16'h0000, 1'b0);
        pulse_activity();
        repeat (10) @(posedge ref_clk);
        #1;
        check(16'(relay_drive), 16'h0000);
        repeat (30) @(posedge ref_clk);
        #1;
        check({3'h0, relay_drive, 3'h0, led_drive}, 16'h0A0A);
        wr(1'b0, rorm_pkg::OFF_FLAGS, 16'h0000, 1'b0);
        wr(1'b0, rorm_pkg::OFF_OUTPUT, 16'h0000, 1'b0);
        pulse_activity();
        repeat (40) @(posedge ref_clk);
        #1;
        check(16'(relay_drive), 16'h0000);
        $display("loss handling done");
        stop_test();
    end
endmodule : rorm_register_map_bench

// >>> rorm_sync.sv
// Purpose: two-flop synchroniser for the configuration switch pins
// Assumes: pins change slowly compared with the clock
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module rorm_sync #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] pins_sync
);

    logic [W-1:0] stage1_reg;

    // two stages, first read only by the second
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= '0;
            pins_sync <= '0;
        end else begin
            stage1_reg <= pins;
            pins_sync <= stage1_reg;
        end
    end

endmodule : rorm_sync
